// file: verilog/ioc_ctrl_regs.sv
// Purpose: serial-port control registers: commands, sample rate, sleep, filter, dac
// Assumes: mode-3 serial port, 16-bit frames, sclk far slower than sys_clk
// Notes: flash copies survive arst_n and are reset to their defaults only by por_n
module ioc_ctrl_regs #(
	parameter int unsigned TB_FAST_CYC = ioc_pkg::TB_FAST_CYC,
	parameter int unsigned TB_SLOW_CYC = ioc_pkg::TB_SLOW_CYC,
	parameter int unsigned FLASH_CYC = ioc_pkg::FLASH_CYC,
	parameter int unsigned SLEEP_UNIT_CYC = ioc_pkg::SLEEP_UNIT_CYC
) (
	// clock and resets
	input wire logic sys_clk,
	input wire logic arst_n,
	input wire logic por_n,
	// serial port pins
	input wire logic csN,
	input wire logic sclk,
	input wire logic mosi,
	output logic miso,
	// operation controls
	output logic autoNullStart,
	output logic precisionNullStart,
	output logic factoryRestoreStart,
	output logic procRestart,
	output logic sampleTick,
	output logic asleep,
	output logic fastMode,
	output logic [2:0] filterTapsLog2,
	output logic [2:0] rangeSelect,
	output logic originAlign,
	output logic [11:0] dacOut
);
	// ==========================================================
	// pin synchronisers
	logic [2:0] csSync, sclkSync, mosiSync;
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			csSync <= 3'h7;
			sclkSync <= 3'h7;
			mosiSync <= 3'h0;
		end else begin
			csSync <= {csSync[1:0], csN};
			sclkSync <= {sclkSync[1:0], sclk};
			mosiSync <= {mosiSync[1:0], mosi};
		end
	end
	wire csLow = !csSync[1];
	wire csFall = csSync[2] && !csSync[1];
	wire csRise = !csSync[2] && csSync[1];
	wire sclkRise = csLow && !sclkSync[2] && sclkSync[1];
	wire sclkFall = csLow && sclkSync[2] && !sclkSync[1];
	wire mosiBit = mosiSync[1];

	// ==========================================================
	// frame shifter
	logic [15:0] shiftIn, shiftOut, readWord;
	logic [4:0] bitCnt;
	wire frameDone = sclkRise && (bitCnt == ioc_pkg::FRAME_BITS - 5'h01);
	ioc_pkg::ioc_frame_t frame;
	assign frame = {shiftIn[14:0], mosiBit};
	logic softRst, bootLoad;
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			bitCnt <= 5'h00;
			shiftIn <= 16'h0000;
			shiftOut <= 16'h0000;
			miso <= 1'b0;
		end else begin
			if (csFall) begin
				bitCnt <= 5'h00;
				shiftOut <= readWord;
			end else if (sclkRise) begin
				bitCnt <= bitCnt + 5'h01;
				shiftIn <= {shiftIn[14:0], mosiBit};
			end
			if (sclkFall) begin
				miso <= shiftOut[15];
				shiftOut <= {shiftOut[14:0], 1'b0};
			end
		end
	end
	wire wrFrame = frameDone && frame.write;
	wire rdFrame = frameDone && !frame.write;
	wire [6:0] wordAddr = {frame.addr[6:1], 1'b0};
	wire hiByte = frame.addr[0];
	function automatic logic hit(input logic [6:0] a);
		return wrFrame && (wordAddr == a);
	endfunction
	function automatic logic [15:0] merge(input logic [15:0] old);
		return hiByte ? {frame.data, old[7:0]} : {old[15:8], frame.data};
	endfunction
	// clamp filter setting to the floor the range demands
	function automatic logic [15:0] clampRange(input logic [15:0] v);
		logic [2:0] m;
		m = (v[2:0] > ioc_pkg::MAX_TAPS) ? ioc_pkg::MAX_TAPS : v[2:0];
		if (v[10:8] == ioc_pkg::RANGE_75 && m < ioc_pkg::MIN_TAPS_75)
			m = ioc_pkg::MIN_TAPS_75;
		else if (v[10:8] == ioc_pkg::RANGE_150 && m < ioc_pkg::MIN_TAPS_150)
			m = ioc_pkg::MIN_TAPS_150;
		return {5'h00, v[10:8], 5'h00, m};
	endfunction

	// ==========================================================
	// commands: decoded straight from the frame, never stored
	ioc_pkg::ioc_cmd_t cmd;
	assign cmd = (hit(ioc_pkg::ADDR_CMD) && !hiByte) ? {8'h00, frame.data} : '0;
	wire calDone = cmd.autoNull || cmd.precisionNull || cmd.factoryRestore;
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			autoNullStart <= 1'b0;
			precisionNullStart <= 1'b0;
			factoryRestoreStart <= 1'b0;
			procRestart <= 1'b0;
			softRst <= 1'b0;
			bootLoad <= 1'b1;
		end else begin
			bootLoad <= 1'b0;
			autoNullStart <= cmd.autoNull;
			precisionNullStart <= cmd.precisionNull;
			factoryRestoreStart <= cmd.factoryRestore;
			procRestart <= cmd.softReset;
			softRst <= cmd.softReset;
		end
	end

	// ==========================================================
	// flash copies and save sequencer
	logic [15:0] flashMisc, flashSample, flashRange;
	logic [15:0] miscCtrl, samplePeriod, rangeFilter, dacLevel, sleepControl;
	logic flashBusy;
	logic [23:0] flashCnt;
	wire flashDone = flashBusy && (flashCnt == 24'(FLASH_CYC - 1));
	wire flashStart = !flashBusy && (cmd.flashSave || calDone);
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			flashBusy <= 1'b0;
			flashCnt <= 24'h000000;
		end else if (softRst) begin
			flashBusy <= 1'b0;
			flashCnt <= 24'h000000;
		end else if (flashStart) begin
			flashBusy <= 1'b1;
			flashCnt <= 24'h000000;
		end else if (flashBusy) begin
			flashBusy <= !flashDone;
			flashCnt <= flashCnt + 24'h000001;
		end
	end
	// only the low byte of misc control is kept in flash
	always_ff @(posedge sys_clk or negedge por_n) begin
		if (!por_n) begin
			flashMisc <= ioc_pkg::RST_MISC;
			flashSample <= ioc_pkg::RST_SAMPLE;
			flashRange <= ioc_pkg::RST_RANGE;
		end else if (flashDone) begin
			flashMisc <= {8'h00, miscCtrl[7:0]};
			flashSample <= samplePeriod;
			flashRange <= rangeFilter;
		end
	end

	// ==========================================================
	// working registers
	ioc_pkg::ioc_pwr_t pwr, next_pwr;
	wire [15:0] next_sample = merge(samplePeriod), next_dac = merge(dacLevel);
	wire [15:0] next_sleep = merge(sleepControl);
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			miscCtrl <= ioc_pkg::RST_MISC;
			samplePeriod <= ioc_pkg::RST_SAMPLE;
			rangeFilter <= ioc_pkg::RST_RANGE;
			dacLevel <= ioc_pkg::RST_DAC;
			sleepControl <= ioc_pkg::RST_SLEEP;
			dacOut <= 12'h000;
		end else if (softRst || bootLoad) begin
			miscCtrl <= flashMisc;
			samplePeriod <= flashSample;
			rangeFilter <= flashRange;
			dacLevel <= ioc_pkg::RST_DAC;
			sleepControl <= ioc_pkg::RST_SLEEP;
			dacOut <= 12'h000;
		end else begin
			if (hit(ioc_pkg::ADDR_MISC))
				miscCtrl <= merge(miscCtrl);
			if (hit(ioc_pkg::ADDR_SAMPLE))
				samplePeriod <= {8'h00, next_sample[7:0]};
			if (hit(ioc_pkg::ADDR_RANGE))
				rangeFilter <= clampRange(merge(rangeFilter));
			if (hit(ioc_pkg::ADDR_DAC))
				dacLevel <= {4'h0, next_dac[ioc_pkg::DAC_MSB:0]};
			if (hit(ioc_pkg::ADDR_SLEEP))
				sleepControl <= {7'h00, next_sleep[ioc_pkg::SLEEP_INDEF_BIT:0]};
			else if (pwr != ioc_pkg::PWR_AWAKE && next_pwr == ioc_pkg::PWR_AWAKE)
				sleepControl <= ioc_pkg::RST_SLEEP;
			// byte writes alone never move the pin level
			if (cmd.dacLatch)
				dacOut <= dacLevel[ioc_pkg::DAC_MSB:0];
		end
	end

	// ==========================================================
	// shutdown control
	logic sleepArmed, wakePend;
	logic [24:0] unitCnt;
	logic [7:0] unitsLeft;
	wire unitDone = (unitCnt == 25'(SLEEP_UNIT_CYC - 1));
	wire timedEnd = pwr == ioc_pkg::PWR_TIMED && unitDone && unitsLeft == 8'h01;
	wire wakeNow = csRise && wakePend;
	always_comb begin
		next_pwr = pwr;
		case (pwr)
			ioc_pkg::PWR_AWAKE: begin
				if (csRise && sleepArmed) begin
					if (sleepControl[ioc_pkg::SLEEP_INDEF_BIT])
						next_pwr = ioc_pkg::PWR_INDEF;
					else if (sleepControl[7:0] != 8'h00)
						next_pwr = ioc_pkg::PWR_TIMED;
				end
			end
			ioc_pkg::PWR_TIMED: begin
				if (wakeNow || timedEnd)
					next_pwr = ioc_pkg::PWR_AWAKE;
			end
			ioc_pkg::PWR_INDEF: begin
				if (wakeNow)
					next_pwr = ioc_pkg::PWR_AWAKE;
			end
			default: next_pwr = ioc_pkg::PWR_AWAKE;
		endcase
	end
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			pwr <= ioc_pkg::PWR_AWAKE;
			sleepArmed <= 1'b0;
			wakePend <= 1'b0;
			unitCnt <= 25'h0000000;
			unitsLeft <= 8'h00;
		end else if (softRst) begin
			pwr <= ioc_pkg::PWR_AWAKE;
			sleepArmed <= 1'b0;
			wakePend <= 1'b0;
			unitCnt <= 25'h0000000;
			unitsLeft <= 8'h00;
		end else begin
			pwr <= next_pwr;
			if (hit(ioc_pkg::ADDR_SLEEP))
				sleepArmed <= 1'b1;
			else if (csRise)
				sleepArmed <= 1'b0;
			// the rise that starts sleep must not count as a wake pulse
			wakePend <= (pwr != ioc_pkg::PWR_AWAKE) && !wakeNow && (wakePend || csFall);
			if (pwr == ioc_pkg::PWR_AWAKE) begin
				unitCnt <= 25'h0000000;
				unitsLeft <= sleepControl[7:0];
			end else if (pwr == ioc_pkg::PWR_TIMED) begin
				unitCnt <= unitDone ? 25'h0000000 : unitCnt + 25'h0000001;
				if (unitDone)
					unitsLeft <= unitsLeft - 8'h01;
			end
		end
	end
	assign asleep = (pwr != ioc_pkg::PWR_AWAKE);

	// ==========================================================
	// sample period timer
	logic [19:0] tbCnt;
	logic [6:0] multCnt;
	wire tbSlow = samplePeriod[ioc_pkg::SAMPLE_TB_BIT];
	wire [19:0] tbLast = tbSlow ? 20'(TB_SLOW_CYC - 1) : 20'(TB_FAST_CYC - 1);
	wire tbDone = (tbCnt >= tbLast);
	wire periodDone = tbDone && (multCnt >= samplePeriod[6:0]);
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			tbCnt <= 20'h00000;
			multCnt <= 7'h00;
			sampleTick <= 1'b0;
		end else if (asleep || softRst) begin
			tbCnt <= 20'h00000;
			multCnt <= 7'h00;
			sampleTick <= 1'b0;
		end else begin
			tbCnt <= tbDone ? 20'h00000 : tbCnt + 20'h00001;
			if (tbDone)
				multCnt <= periodDone ? 7'h00 : multCnt + 7'h01;
			sampleTick <= periodDone;
		end
	end

	// ==========================================================
	// status and read-back
	logic [15:0] statusWord;
	always_comb begin
		statusWord = 16'h0000;
		statusWord[ioc_pkg::STATUS_FLASH_ERR_BIT] = 1'b0;
		statusWord[ioc_pkg::STATUS_FLASH_BUSY_BIT] = flashBusy;
		statusWord[ioc_pkg::STATUS_ASLEEP_BIT] = asleep;
	end
	wire [15:0] readMux =
		(wordAddr == ioc_pkg::ADDR_DAC) ? dacLevel :
		(wordAddr == ioc_pkg::ADDR_MISC) ? miscCtrl :
		(wordAddr == ioc_pkg::ADDR_SAMPLE) ? samplePeriod :
		(wordAddr == ioc_pkg::ADDR_RANGE) ? rangeFilter :
		(wordAddr == ioc_pkg::ADDR_SLEEP) ? sleepControl :
		(wordAddr == ioc_pkg::ADDR_STATUS) ? statusWord : 16'h0000;
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n)
			readWord <= 16'h0000;
		else if (rdFrame)
			readWord <= readMux;
	end
	assign fastMode = (samplePeriod[7:0] <= ioc_pkg::FAST_MODE_MAX);
	assign filterTapsLog2 = rangeFilter[2:0];
	assign rangeSelect = rangeFilter[10:8];
	assign originAlign = miscCtrl[ioc_pkg::MISC_ALIGN_BIT];

	// ==========================================================
	// checks
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!arst_n);
	a_dac_latch_load: assert property (cmd.dacLatch && !softRst |=> dacOut == $past(dacLevel[ioc_pkg::DAC_MSB:0]))
		else $error("dac latch did not load level");
	a_cal_then_flash: assert property (calDone && !flashBusy |=> flashBusy)
		else $error("calibration not followed by flash save");
	a_flash_end_count: assert property ($fell(flashBusy) && !$past(softRst) |-> $past(flashCnt) == 24'(FLASH_CYC - 1))
		else $error("flash save ended at wrong count");
	a_sleep_no_tick: assert property (asleep |=> !sampleTick)
		else $error("sample tick while asleep");
	a_range_floor: assert property (rangeFilter[10:8] == ioc_pkg::RANGE_75 |-> rangeFilter[2:0] >= ioc_pkg::MIN_TAPS_75)
		else $error("filter below floor for 75 range");
	a_cmd_reads_zero: assert property (rdFrame && wordAddr == ioc_pkg::ADDR_CMD |=> readWord == 16'h0000)
		else $error("command register read nonzero");
	a_wake_pulse: assert property (asleep && wakeNow && !softRst |=> !asleep)
		else $error("chip select pulse did not wake");
	a_indef_entry: assert property (pwr == ioc_pkg::PWR_AWAKE && csRise && sleepArmed && sleepControl[ioc_pkg::SLEEP_INDEF_BIT] && !softRst |=> pwr == ioc_pkg::PWR_INDEF ##1 asleep)
		else $error("indefinite sleep not entered");
	a_soft_reset_dac: assert property (softRst |=> dacLevel == 16'h0000 && dacOut == 12'h000)
		else $error("software reset left dac state");
	c_timed_sleep: cover property (pwr == ioc_pkg::PWR_TIMED ##1 timedEnd);
	c_flash_save: cover property ($fell(flashBusy));
	c_sample_tick: cover property (sampleTick);
	c_dac_latch: cover property (cmd.dacLatch);
endmodule

// file: verilog/ioc_pkg.sv
// Purpose: shared constants and types for the operational control registers
// Assumes: 50 MHz sys_clk, 16-bit sampled serial frames
// Notes: times are kept in their own units; cycle counts derive from them
package ioc_pkg;
	// ==========================================================
	// clock and times
	localparam int unsigned CLK_HZ = 50_000_000;
	localparam int unsigned CLK_NS = 1_000_000_000 / CLK_HZ;
	localparam int unsigned TB_FAST_NS = 610_350;      // 0.61035 ms
	localparam int unsigned TB_SLOW_NS = 18_921_000;   // 18.921 ms
	localparam int unsigned FLASH_MS = 100;
	localparam int unsigned SLEEP_UNIT_MS = 500;       // 0.5 s per count
	localparam int unsigned TB_FAST_CYC = TB_FAST_NS / CLK_NS;
	localparam int unsigned TB_SLOW_CYC = TB_SLOW_NS / CLK_NS;
	localparam int unsigned FLASH_CYC = FLASH_MS * (CLK_HZ / 1000);
	localparam int unsigned SLEEP_UNIT_CYC = SLEEP_UNIT_MS * (CLK_HZ / 1000);
	// ==========================================================
	// register byte addresses
	localparam logic [6:0] ADDR_DAC = 7'h30;
	localparam logic [6:0] ADDR_MISC = 7'h34;
	localparam logic [6:0] ADDR_SAMPLE = 7'h36;
	localparam logic [6:0] ADDR_RANGE = 7'h38;
	localparam logic [6:0] ADDR_SLEEP = 7'h3a;
	localparam logic [6:0] ADDR_STATUS = 7'h3c;
	localparam logic [6:0] ADDR_CMD = 7'h3e;
	// ==========================================================
	// reset values and fields
	localparam logic [15:0] RST_DAC = 16'h0000;
	localparam logic [15:0] RST_MISC = 16'h0000;
	localparam logic [15:0] RST_SAMPLE = 16'h0001;
	localparam logic [15:0] RST_RANGE = 16'h0402;
	localparam logic [15:0] RST_SLEEP = 16'h0000;
	localparam int unsigned DAC_MSB = 11;
	localparam int unsigned MISC_ALIGN_BIT = 6;
	localparam int unsigned SAMPLE_TB_BIT = 7;
	localparam int unsigned SLEEP_INDEF_BIT = 8;
	localparam int unsigned STATUS_FLASH_ERR_BIT = 2;
	localparam int unsigned STATUS_FLASH_BUSY_BIT = 3;
	localparam int unsigned STATUS_ASLEEP_BIT = 4;
	localparam logic [7:0] FAST_MODE_MAX = 8'h09;
	localparam logic [2:0] RANGE_300 = 3'h4;
	localparam logic [2:0] RANGE_150 = 3'h2;
	localparam logic [2:0] RANGE_75 = 3'h1;
	localparam logic [2:0] MIN_TAPS_150 = 3'h2;
	localparam logic [2:0] MIN_TAPS_75 = 3'h4;
	localparam logic [2:0] MAX_TAPS = 3'h6;
	localparam logic [4:0] FRAME_BITS = 5'h10;
	// ==========================================================
	// types
	typedef struct packed {
		logic [7:0] unused;
		logic softReset;
		logic [1:0] spare;
		logic precisionNull;
		logic flashSave;
		logic dacLatch;
		logic factoryRestore;
		logic autoNull;
	} ioc_cmd_t;
	typedef struct packed {
		logic write;
		logic [6:0] addr;
		logic [7:0] data;
	} ioc_frame_t;
	typedef enum logic [1:0] {
		PWR_AWAKE = 2'b00,
		PWR_TIMED = 2'b01,
		PWR_INDEF = 2'b10
	} ioc_pwr_t;
endpackage

// file: testbench/ioc_host_model.sv
// Purpose: serial host driving mode-3 frames into the control registers
// Assumes: 160 ns link clock, inputs changed on sys_clk falling edge
// Notes: link clock stands high between frames; released mosi shows the inverse
module ioc_host_model (
	// clock
	input wire logic sys_clk,
	// serial port
	output logic csN,
	output logic sclk,
	output logic mosi,
	input wire logic miso
);
	timeunit 1ns;
	timeprecision 1ps;
	// ==========================================================
	// link timing
	localparam int HALF = 4; // one fixed bench link rate
	initial begin
		csN = 1'b1;
		sclk = 1'b1;
		mosi = 1'b0;
	end
	task automatic wait_clk(input int n);
		repeat (n) @(negedge sys_clk);
	endtask
	// ==========================================================
	// one 16-bit frame; rx holds what miso shifted out
	task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
		rx = 16'h0000;
		@(negedge sys_clk);
		csN = 1'b0;
		for (int i = 15; i >= 0; i--) begin
			wait_clk(HALF);
			sclk = 1'b0;
			mosi = tx[i];
			wait_clk(HALF);
			rx = {rx[14:0], miso};
			sclk = 1'b1;
		end
		wait_clk(HALF);
		csN = 1'b1;
		mosi = ~mosi;
		wait_clk(8);
	endtask
	// chip select dip with no clocks, used as a wake request
	task automatic cs_pulse();
		@(negedge sys_clk);
		csN = 1'b0;
		wait_clk(HALF);
		csN = 1'b1;
		wait_clk(8);
	endtask
endmodule

// file: testbench/tb_top.sv
// Purpose: self-checking bench for the operational control registers
// Assumes: long counts shortened by parameters, expectations follow them
// Notes: registers reached only through serial frames of the host model
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	// ==========================================================
	// scaled counts
	localparam int FAST = 8;
	localparam int SLOW = 20;
	localparam int UNIT = 200;
	logic sys_clk, arst_n, por_n, csN, sclk, mosi, miso;
	logic autoNullStart, precisionNullStart, factoryRestoreStart, procRestart;
	logic sampleTick, asleep, fastMode, originAlign;
	logic [2:0] filterTapsLog2, rangeSelect;
	logic [11:0] dacOut;
	int miscompares = 0;
	int numChecks = 0;
	int pulseCnt [4];
	int tickCnt = 0;
	ioc_ctrl_regs #(.TB_FAST_CYC(FAST), .TB_SLOW_CYC(SLOW), .FLASH_CYC(16),
		.SLEEP_UNIT_CYC(UNIT)) uut (.sys_clk(sys_clk), .arst_n(arst_n), .por_n(por_n),
		.csN(csN), .sclk(sclk), .mosi(mosi), .miso(miso), .autoNullStart(autoNullStart),
		.precisionNullStart(precisionNullStart), .factoryRestoreStart(factoryRestoreStart),
		.procRestart(procRestart), .sampleTick(sampleTick), .asleep(asleep),
		.fastMode(fastMode), .filterTapsLog2(filterTapsLog2), .rangeSelect(rangeSelect),
		.originAlign(originAlign), .dacOut(dacOut));
	ioc_host_model host (.sys_clk(sys_clk), .csN(csN), .sclk(sclk), .mosi(mosi), .miso(miso));
	initial begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end
	always @(negedge sys_clk) begin
		if (autoNullStart === 1'b1) pulseCnt[0]++;
		if (factoryRestoreStart === 1'b1) pulseCnt[1]++;
		if (precisionNullStart === 1'b1) pulseCnt[2]++;
		if (procRestart === 1'b1) pulseCnt[3]++;
		if (sampleTick === 1'b1) tickCnt++;
	end
	// ==========================================================
	// compare and access tasks
	task automatic final_report();
		$display("checks %0d mismatches %0d", numChecks, miscompares);
		if (miscompares == 0 && numChecks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
		numChecks++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic chk_bit(input logic got, input logic exp);
		chk_word({15'h0000, got}, {15'h0000, exp});
	endtask
	task automatic chk_cnt(input int got, input int exp);
		chk_word(got[15:0], exp[15:0]);
	endtask
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		logic [15:0] r;
		host.xfer({1'b1, a, d}, r);
	endtask
	// read answer arrives in the following frame
	task automatic rchk(input logic [6:0] a, input logic [15:0] e);
		logic [15:0] r;
		host.xfer({1'b0, a, 8'h00}, r);
		host.xfer({1'b0, a, 8'h00}, r);
		chk_word(r, e);
	endtask
	task automatic measure(output int n);
		int w;
		repeat (2) begin
			w = 0;
			@(negedge sys_clk);
			while (sampleTick !== 1'b1 && w < 500) begin
				@(negedge sys_clk);
				w++;
			end
		end
		n = 0;
		do begin
			@(negedge sys_clk);
			n++;
		end while (sampleTick !== 1'b1 && n < 500);
	endtask
	initial begin
		#2_000_000;
		miscompares++;
		final_report();
	end
	// ==========================================================
	// tests
	initial begin
		static logic [7:0] spv [4] = '{8'h01, 8'h09, 8'h0a, 8'h83};
		static int spn [4] = '{FAST * 2, FAST * 10, FAST * 11, SLOW * 4};
		static logic [7:0] rhi [4] = '{8'h01, 8'h02, 8'h04, 8'h04};
		static logic [7:0] rlo [4] = '{8'h00, 8'h01, 8'h07, 8'h03};
		static logic [15:0] rex [4] = '{16'h0104, 16'h0202, 16'h0406, 16'h0403};
		static logic [7:0] cmds [3] = '{8'h01, 8'h02, 8'h10};
		int n;
		arst_n = 1'b0;
		por_n = 1'b0;
		pulseCnt = '{0, 0, 0, 0};
		repeat (16) @(negedge sys_clk);
		arst_n = 1'b1;
		por_n = 1'b1;
		host.wait_clk(4);
		chk_word({1'b0, fastMode, originAlign, asleep, dacOut}, 16'h4000);
		chk_word({10'h000, rangeSelect, filterTapsLog2}, 16'h0022);
		rchk(7'h30, 16'h0000);
		rchk(7'h36, 16'h0001);
		rchk(7'h38, 16'h0402);
		rchk(7'h3a, 16'h0000);
		rchk(7'h50, 16'h0000);
		for (int k = 0; k < 4; k++) begin
			wr(7'h36, spv[k]);
			measure(n);
			chk_cnt(n, spn[k]);
			chk_bit(fastMode, spv[k] <= 8'h09);
		end
		// range byte first, then filter byte
		for (int k = 0; k < 4; k++) begin
			wr(7'h39, rhi[k]);
			wr(7'h38, rlo[k]);
			rchk(7'h38, rex[k]);
			chk_word({10'h000, rangeSelect, filterTapsLog2}, {10'h000, rex[k][10:8], rex[k][2:0]});
		end
		wr(7'h30, 8'hff);
		wr(7'h31, 8'hff);
		chk_word({4'h0, dacOut}, 16'h0000);
		rchk(7'h30, 16'h0fff);
		wr(7'h3e, 8'h04);
		chk_word({4'h0, dacOut}, 16'h0fff);
		rchk(7'h3e, 16'h0000);
		wr(7'h36, 8'h06);
		wr(7'h3e, 8'h08);
		host.wait_clk(40);
		wr(7'h34, 8'h40);
		chk_bit(originAlign, 1'b1);
		for (int k = 0; k < 3; k++) begin
			pulseCnt = '{0, 0, 0, 0};
			wr(7'h3e, cmds[k]);
			host.wait_clk(40);
			for (int j = 0; j < 4; j++) chk_cnt(pulseCnt[j], int'(j == k));
		end
		// unused command bits start nothing
		pulseCnt = '{0, 0, 0, 0};
		wr(7'h3e, 8'h60);
		host.wait_clk(40);
		chk_cnt(pulseCnt[0] + pulseCnt[1] + pulseCnt[2] + pulseCnt[3], 0);
		rchk(7'h3c, 16'h0000);
		wr(7'h34, 8'h00);
		wr(7'h36, 8'h07);
		wr(7'h30, 8'h34);
		wr(7'h3e, 8'h80);
		chk_cnt(pulseCnt[3], 1);
		rchk(7'h36, 16'h0006);
		rchk(7'h34, 16'h0040);
		rchk(7'h30, 16'h0000);
		chk_word({4'h0, dacOut}, 16'h0000);
		// reset pin alone restarts from the saved copies, like the command
		arst_n = 1'b0;
		repeat (16) @(negedge sys_clk);
		arst_n = 1'b1;
		host.wait_clk(4);
		rchk(7'h36, 16'h0006);
		rchk(7'h34, 16'h0040);
		// timed sleep of two units
		wr(7'h3a, 8'h02);
		chk_bit(asleep, 1'b1);
		tickCnt = 0;
		host.wait_clk(UNIT + UNIT / 2);
		chk_bit(asleep, 1'b1);
		chk_cnt(tickCnt, 0);
		host.wait_clk(UNIT * 3 / 4);
		chk_bit(asleep, 1'b0);
		measure(n);
		chk_cnt(n, FAST * 7);
		wr(7'h3b, 8'h01);
		host.wait_clk(5 * UNIT);
		chk_bit(asleep, 1'b1);
		host.cs_pulse();
		chk_bit(asleep, 1'b0);
		final_report();
	end
endmodule
